// ---- rtl/cpg_powerdown_guard.sv ----
// power-up clear, pin power-down, test load and security fuse core
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module cpg_powerdown_guard
   import cpg_pkg::*;
#(
   parameter int          NMC         = 32,
   parameter int          POR_CYCLES  = CPG_POR_CYC,
   parameter int          WAKE_CYCLES = CPG_WAKE_CYC,
   parameter logic [159:0] SIG_INIT   = 160'h0 // arbitrary value
) (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [7:0]     s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   input  wire logic [7:0]     s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready,
   input  wire logic           sleep_hold_pin,
   input  wire logic [NMC-1:0] user_in,
   output logic [NMC-1:0]      user_out,
   output logic [NMC-1:0]      user_oe,
   output logic                sleep_term
);

   // pins fit one 32-bit word and the timers a 16-bit counter
   if (NMC < 1 || NMC > 32 || POR_CYCLES < 1 || WAKE_CYCLES < 1 ||
       POR_CYCLES > 65535 || WAKE_CYCLES > 65535) begin : g_bad_param
      $error("cpg_powerdown_guard: parameter out of range");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic           sleep_m_r;
   logic           sleep_s_r;
   logic [NMC-1:0] in_m_r;
   logic [NMC-1:0] in_s_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_m_r <= 1'b0;
         sleep_s_r <= 1'b0;
         in_m_r    <= '0;
         in_s_r    <= '0;
      end else begin
         sleep_m_r <= sleep_hold_pin;
         sleep_s_r <= sleep_m_r;
         in_m_r    <= user_in;
         in_s_r    <= in_m_r;
      end
   end

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic           pd_en_r;
   logic           fuse_r;
   logic           refused_r;
   logic [NMC-1:0] slew_r;
   logic [NMC-1:0] oecfg_r;
   logic [NMC-1:0] loaddat_r;
   logic [31:0]    sig_r [CPG_SIG_WORDS];
   logic [NMC-1:0] mc_r;
   logic [NMC-1:0] pin_hold_r;
   logic [NMC-1:0] oe_r;
   cpg_state_t     state_r;
   cpg_state_t     state_nxt;
   logic [15:0]    cnt_r;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic        aw_full_r;
   logic        w_full_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   wire        do_wr    = aw_full_r && w_full_r && !bvalid_r;
   wire        wr_ctrl  = do_wr && awaddr_r == CPG_CTRL_OFS;
   wire        wr_slew  = do_wr && awaddr_r == CPG_SLEW_OFS;
   wire        wr_oe    = do_wr && awaddr_r == CPG_OECFG_OFS;
   wire        wr_ld    = do_wr && awaddr_r == CPG_LOADDAT_OFS;
   wire [7:0]  wsig_off = awaddr_r - CPG_SIG_OFS;
   wire [7:0]  rsig_off = s_axi_araddr - CPG_SIG_OFS;
   wire        wr_sig   = do_wr && awaddr_r >= CPG_SIG_OFS &&
                          wsig_off < 8'(CPG_SIG_WORDS * 4) &&
                          awaddr_r[1:0] == 2'h0;
   wire        wr_ok    = wr_ctrl || wr_slew || wr_oe || wr_ld || wr_sig ||
                          (do_wr && awaddr_r == CPG_STATUS_OFS) ||
                          (do_wr && awaddr_r == CPG_STATE_OFS);
   wire [31:0] ctrl_new = cpg_merge(CPG_ZERO_RST, wdata_r, wstrb_r);

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   wire active   = state_r == CPG_ST_RUN;
   wire pd_req   = pd_en_r && sleep_s_r;
   wire cnt_done = cnt_r == 16'(POR_CYCLES - 1) && state_r == CPG_ST_POR ||
                   cnt_r == 16'(WAKE_CYCLES - 1) && state_r == CPG_ST_WAKE;

   always_comb begin
      case (state_r)
         CPG_ST_POR:  state_nxt = cnt_done ? CPG_ST_RUN : CPG_ST_POR;
         CPG_ST_RUN:  state_nxt = pd_req ? CPG_ST_DOWN : CPG_ST_RUN;
         CPG_ST_DOWN: state_nxt = pd_req ? CPG_ST_DOWN : CPG_ST_WAKE;
         CPG_ST_WAKE: state_nxt = pd_req   ? CPG_ST_DOWN :
                                  cnt_done ? CPG_ST_RUN  : CPG_ST_WAKE;
         default:     state_nxt = CPG_ST_POR;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= CPG_ST_POR;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= (state_nxt != state_r) ? 16'h0 : cnt_r + 16'h1;
      end
   end

   // the fuse bites in the very write that sets it
   wire fuse_eff = fuse_r || (wr_ctrl && ctrl_new[CTRL_FUSE_BIT]);
   wire load_req = wr_ctrl && ctrl_new[CTRL_LOAD_BIT];
   wire load_do  = load_req && !fuse_eff && active;

   // sleep pin term into the logic array: gone once the pin is the control
   assign sleep_term = sleep_s_r && !pd_en_r;

   // ----------------------------------------------------------------
   // macrocells, hold latches and enables
   // ----------------------------------------------------------------
   wire [NMC-1:0] mc_d = pin_hold_r | NMC'(sleep_term);

   always_ff @(posedge aclk) begin
      if (!aresetn || state_r == CPG_ST_POR) begin
         mc_r       <= '0;
         pin_hold_r <= '0;
         oe_r       <= '0;
      end else if (load_do) begin
         mc_r       <= loaddat_r;
      end else if (active) begin
         // nothing moves outside RUN, so wake resumes from held state
         mc_r       <= mc_d;
         pin_hold_r <= in_s_r;
         oe_r       <= oecfg_r;
      end
   end

   assign user_oe = oe_r;

   cpg_out_stage #(
      .NMC     (NMC)
   ) u_out (
      .aclk    (aclk),
      .aresetn (aresetn),
      .freeze  (!active),
      .fast    (slew_r),
      .d       (mc_r),
      .q       (user_out)
   );

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_en_r   <= 1'b0;
         fuse_r    <= 1'b0;
         refused_r <= 1'b0;
         slew_r    <= '0;
         oecfg_r   <= '0;
         loaddat_r <= '0;
         for (int i = 0; i < CPG_SIG_WORDS; i++) begin
            sig_r[i] <= SIG_INIT[i*32 +: 32];
         end
      end else begin
         if (wr_ctrl) begin
            pd_en_r <= ctrl_new[CTRL_PD_EN_BIT];
         end
         if (fuse_eff) begin
            fuse_r <= 1'b1;
         end
         // a refusal in the clearing write still sets the flag
         if (load_req && !load_do) begin
            refused_r <= 1'b1;
         end else if (wr_ctrl && ctrl_new[CTRL_CLRERR_BIT]) begin
            refused_r <= 1'b0;
         end
         if (wr_slew) begin
            slew_r <= NMC'(cpg_merge(32'(slew_r), wdata_r, wstrb_r));
         end
         if (wr_oe) begin
            oecfg_r <= NMC'(cpg_merge(32'(oecfg_r), wdata_r, wstrb_r));
         end
         if (wr_ld) begin
            loaddat_r <= NMC'(cpg_merge(32'(loaddat_r), wdata_r, wstrb_r));
         end
         if (wr_sig && !fuse_r) begin
            sig_r[wsig_off[4:2]] <= cpg_merge(sig_r[wsig_off[4:2]],
                                              wdata_r, wstrb_r);
         end
      end
   end

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_full_r && !bvalid_r;
   assign s_axi_wready  = !w_full_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         bvalid_r  <= 1'b0;
         bresp_r   <= CPG_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_ok ? CPG_RESP_OKAY : CPG_RESP_SLV;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   wire [31:0] status_w = {27'h0, refused_r, fuse_r,
                           state_r == CPG_ST_WAKE, state_r == CPG_ST_DOWN,
                           state_r == CPG_ST_POR};
   // verify readback of configuration is blanked once the fuse is set
   wire [31:0] cfg_mask = fuse_r ? 32'h0 : 32'hffff_ffff;
   wire        rd_sig   = s_axi_araddr >= CPG_SIG_OFS &&
                          rsig_off < 8'(CPG_SIG_WORDS * 4) &&
                          s_axi_araddr[1:0] == 2'h0;
   wire        rd_ok    = rd_sig || s_axi_araddr == CPG_CTRL_OFS ||
                          s_axi_araddr == CPG_STATUS_OFS ||
                          s_axi_araddr == CPG_SLEW_OFS ||
                          s_axi_araddr == CPG_OECFG_OFS ||
                          s_axi_araddr == CPG_LOADDAT_OFS ||
                          s_axi_araddr == CPG_STATE_OFS;
   wire [31:0] rd_word  =
      s_axi_araddr == CPG_CTRL_OFS    ? {31'h0, pd_en_r} :
      s_axi_araddr == CPG_STATUS_OFS  ? status_w :
      s_axi_araddr == CPG_SLEW_OFS    ? 32'(slew_r) & cfg_mask :
      s_axi_araddr == CPG_OECFG_OFS   ? 32'(oecfg_r) & cfg_mask :
      s_axi_araddr == CPG_LOADDAT_OFS ? 32'(loaddat_r) & cfg_mask :
      s_axi_araddr == CPG_STATE_OFS   ? 32'(mc_r) & cfg_mask :
      rd_sig                          ? sig_r[rsig_off[4:2]] : 32'h0;

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= CPG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= rd_ok ? CPG_RESP_OKAY : CPG_RESP_SLV;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_por_low;
      @(posedge aclk) disable iff (!aresetn)
      state_r == CPG_ST_POR |=> user_out == '0 && mc_r == '0;
   endproperty
   a_por_low: assert property (p_por_low)
      else $error("outputs not low during power-up clear");

   property p_pd_enter;
      @(posedge aclk) disable iff (!aresetn)
      active && pd_en_r && sleep_s_r |=> state_r == CPG_ST_DOWN;
   endproperty
   a_pd_enter: assert property (p_pd_enter)
      else $error("sleep pin high did not enter power-down");

   property p_pd_off;
      @(posedge aclk) disable iff (!aresetn)
      !pd_en_r |-> state_r != CPG_ST_DOWN || $past(pd_en_r);
   endproperty
   a_pd_off: assert property (p_pd_off)
      else $error("power-down entered while feature disabled");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      state_r == CPG_ST_DOWN ##1 state_r == CPG_ST_DOWN
      |-> $stable(mc_r) && $stable(user_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("state moved during power-down");

   property p_oe_hold;
      @(posedge aclk) disable iff (!aresetn)
      state_r == CPG_ST_DOWN |=> $stable(user_oe);
   endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("output enable changed during power-down");

   property p_in_block;
      @(posedge aclk) disable iff (!aresetn)
      !active && state_r != CPG_ST_POR |=> $stable(pin_hold_r);
   endproperty
   a_in_block: assert property (p_in_block)
      else $error("input reached logic while blocked");

   property p_sleep_term;
      @(posedge aclk) disable iff (!aresetn)
      active && pd_en_r && !load_do |=> mc_r == $past(pin_hold_r);
   endproperty
   a_sleep_term: assert property (p_sleep_term)
      else $error("sleep pin array input visible");

   property p_slow;
      @(posedge aclk) disable iff (!aresetn)
      active ##1 (active && !slew_r[0]) ##1 !slew_r[0]
      |-> user_out[0] == $past(mc_r[0], 2);
   endproperty
   a_slow: assert property (p_slow)
      else $error("slow output timing wrong");

   property p_fuse;
      @(posedge aclk) disable iff (!aresetn)
      load_req && fuse_r |=> refused_r && ($stable(mc_r) || $past(active));
   endproperty
   a_fuse: assert property (p_fuse)
      else $error("test load not refused under fuse");

   property p_load;
      @(posedge aclk) disable iff (!aresetn)
      load_do |=> mc_r == $past(loaddat_r);
   endproperty
   a_load: assert property (p_load)
      else $error("test load did not force the macrocells");

   property p_resume;
      @(posedge aclk) disable iff (!aresetn)
      state_r == CPG_ST_DOWN ##1 state_r == CPG_ST_WAKE |-> $stable(mc_r);
   endproperty
   a_resume: assert property (p_resume)
      else $error("held state altered on leaving power-down");

   c_enter: cover property (@(posedge aclk) disable iff (!aresetn)
      active ##1 state_r == CPG_ST_DOWN);
   c_wake:  cover property (@(posedge aclk) disable iff (!aresetn)
      state_r == CPG_ST_WAKE ##1 active);
   c_load:  cover property (@(posedge aclk) disable iff (!aresetn)
      load_do);
   c_refuse: cover property (@(posedge aclk) disable iff (!aresetn)
      load_req && fuse_r);

endmodule : cpg_powerdown_guard

// ---- rtl/cpg_pkg.sv ----
// shared constants for the power-down and reset guard
package cpg_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CPG_CTRL_OFS    = 8'h00;
   localparam logic [7:0] CPG_STATUS_OFS  = 8'h04;
   localparam logic [7:0] CPG_SLEW_OFS    = 8'h08;
   localparam logic [7:0] CPG_OECFG_OFS   = 8'h0c;
   localparam logic [7:0] CPG_LOADDAT_OFS = 8'h10;
   localparam logic [7:0] CPG_STATE_OFS   = 8'h14;
   localparam logic [7:0] CPG_SIG_OFS     = 8'h20;
   localparam int         CPG_SIG_WORDS   = 5;
   localparam int         CPG_SIG_BITS    = 160;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_PD_EN_BIT  = 0;
   localparam int CTRL_LOAD_BIT   = 1;
   localparam int CTRL_FUSE_BIT   = 2;
   localparam int CTRL_CLRERR_BIT = 3;
   localparam int STAT_POR_BIT    = 0;
   localparam int STAT_DOWN_BIT   = 1;
   localparam int STAT_WAKE_BIT   = 2;
   localparam int STAT_FUSE_BIT   = 3;
   localparam int STAT_REFUSE_BIT = 4;
   localparam logic [31:0] CPG_ZERO_RST  = 32'h0000_0000;
   localparam logic [1:0]  CPG_RESP_OKAY = 2'h0;
   localparam logic [1:0]  CPG_RESP_SLV  = 2'h2;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CPG_CLK_MHZ   = 25;
   localparam int CPG_TPR_US    = 10;
   localparam int CPG_TWAKE_US  = 1;
   localparam int CPG_POR_CYC   = CPG_TPR_US * CPG_CLK_MHZ;
   localparam int CPG_WAKE_CYC  = CPG_TWAKE_US * CPG_CLK_MHZ;

   // ----------------------------------------------------------------
   // power state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CPG_ST_POR  = 4'h1,
      CPG_ST_RUN  = 4'h2,
      CPG_ST_DOWN = 4'h4,
      CPG_ST_WAKE = 4'h8
   } cpg_state_t;

   function automatic logic [31:0] cpg_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction : cpg_merge

endpackage : cpg_pkg

// ---- rtl/cpg_out_stage.sv ----
// output stage with per-pin slow or fast edge timing
`timescale 1ns/1ns
module cpg_out_stage #(
   parameter int NMC = 32
) (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic           freeze,
   input  wire logic [NMC-1:0] fast,
   input  wire logic [NMC-1:0] d,
   output logic      [NMC-1:0] q
);

   logic [NMC-1:0] q1_r;
   logic [NMC-1:0] q2_r;
   logic [NMC-1:0] fast_r;

   // ----------------------------------------------------------------
   // stage registers, frozen with the core
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q1_r   <= '0;
         q2_r   <= '0;
         fast_r <= '0;
      end else if (!freeze) begin
         q1_r   <= d;
         q2_r   <= q1_r;
         // slew follows its setting only while running, so a write
         // during power-down cannot move a held pin
         fast_r <= fast;
      end
   end

   // slow pins pay one extra cycle, the stand-in for the edge adder
   generate
      for (genvar i = 0; i < NMC; i++) begin : g_pin
         assign q[i] = fast_r[i] ? q1_r[i] : q2_r[i];
      end
   endgenerate

endmodule : cpg_out_stage

// ---- verif/cpg_board_model.sv ----
// board model driving the sleep hold pin and the input pins
`timescale 1ns/1ns
module cpg_board_model (
   input  wire logic        aclk,
   input  wire logic        pd_cmd,
   input  wire logic [31:0] in_cmd,
   output logic             sleep_hold_pin,
   output logic [31:0]      user_in
);
   // levels defined from time zero, nothing toggles during reset
   initial begin
      sleep_hold_pin = 1'b0;
      user_in        = 32'h0000_0000;
      // pins move just after an edge, so setup holds at the next one
      forever begin
         @(posedge aclk);
         sleep_hold_pin <= pd_cmd;
         user_in        <= in_cmd;
      end
   end
endmodule : cpg_board_model

// ---- verif/cpg_powerdown_guard_tb.sv ----
// self-checking bench for the power-down and reset guard
`timescale 1ns/1ns
module cpg_powerdown_guard_tb;
   import cpg_pkg::*;
   localparam logic [31:0] SIG_LO = 32'h5a5a_0f0f; // arbitrary value
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, pd_cmd, pin, term;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, in_cmd, uin, uout, uoe, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   int          err_count, comparisons;
   cpg_board_model u_board (.aclk(aclk), .pd_cmd(pd_cmd), .in_cmd(in_cmd),
      .sleep_hold_pin(pin), .user_in(uin));
   cpg_powerdown_guard #(.NMC(32), .POR_CYCLES(8), .WAKE_CYCLES(4),
      .SIG_INIT({128'h0, SIG_LO})) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sleep_hold_pin(pin), .user_in(uin),
      .user_out(uout), .user_oe(uoe), .sleep_term(term));
   // ----------------------------------------------------------------
   // bus tasks and compares
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t data %h exp %h", $time, g, e);
      end
   endtask : chk_d
   task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t resp %h exp %h", $time, g, e);
      end
   endtask : chk_r
   task automatic hang;
      err_count++;
      $display("CHECK FAILED %0t no bus answer", $time);
      give_verdict();
   endtask : hang
   // ready is sampled mid-cycle, where it has settled for the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      int   n;
      tb = 1'b0;
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40 && !tb; n++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r  = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      if (!tb) hang();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      int   n;
      tr = 1'b0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 40 && !tr; n++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      if (!tr) hang();
   endtask : rd
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, pd_cmd} = '0;
      {awaddr, araddr, wdata, in_cmd} = '0;
      wstrb = 4'hf;
      err_count = 0;
      comparisons = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk_d(uout | uoe, 32'h0);
      rd(CPG_STATUS_OFS);
      chk_d(d[STAT_POR_BIT], 32'h1);
      repeat (12) @(posedge aclk);
      rd(CPG_SLEW_OFS);
      chk_d(d, 32'h0);
      wr(CPG_SLEW_OFS, 32'hffff_0000);
      chk_r(r, CPG_RESP_OKAY);
      rd(CPG_SLEW_OFS);
      chk_d(d, 32'hffff_0000);
      in_cmd <= 32'h3c3c_a5a5;
      repeat (20) @(posedge aclk);
      chk_d(uout, 32'h3c3c_a5a5);
      wr(CPG_LOADDAT_OFS, 32'h0f0f_0f0f);
      wr(CPG_CTRL_OFS, 32'h2);
      rd(CPG_STATUS_OFS);
      chk_d(d[STAT_REFUSE_BIT], 32'h0);
      wr(CPG_OECFG_OFS, 32'hffff_fffe);
      wr(CPG_CTRL_OFS, 32'h1);
      pd_cmd <= 1'b1;
      repeat (10) @(posedge aclk);
      rd(CPG_STATUS_OFS);
      chk_d(d[STAT_DOWN_BIT], 32'h1);
      chk_d(term, 32'h0);
      in_cmd <= 32'h0;
      wr(CPG_OECFG_OFS, 32'hffff_ffff);
      repeat (20) @(posedge aclk);
      chk_d(uout, 32'h3c3c_a5a5);
      chk_d(uoe, 32'hffff_fffe);
      rd(CPG_STATE_OFS);
      chk_d(d, 32'h3c3c_a5a5);
      pd_cmd <= 1'b0;
      repeat (30) @(posedge aclk);
      rd(CPG_STATUS_OFS);
      chk_d(d[STAT_DOWN_BIT], 32'h0);
      chk_d(uout, 32'h0);
      chk_d(uoe, 32'hffff_ffff);
      wr(CPG_CTRL_OFS, 32'h4);
      wr(CPG_CTRL_OFS, 32'h2);
      rd(CPG_STATUS_OFS);
      chk_d(d[STAT_REFUSE_BIT:STAT_FUSE_BIT], 32'h3);
      wr(CPG_CTRL_OFS, 32'h8);
      rd(CPG_STATUS_OFS);
      chk_d(d[STAT_REFUSE_BIT:STAT_FUSE_BIT], 32'h1);
      rd(CPG_SLEW_OFS);
      chk_d(d, 32'h0);
      wr(CPG_SIG_OFS, 32'h0);
      rd(CPG_SIG_OFS);
      chk_d(d, SIG_LO);
      pd_cmd <= 1'b1;
      repeat (6) @(posedge aclk);
      chk_d(term, 32'h1);
      rd(8'h3c);
      chk_r(r, CPG_RESP_SLV);
      give_verdict();
   end
endmodule : cpg_powerdown_guard_tb
